// ===== logic/vcs_sequencer.v
// voltage code sequencer: boot codes, slam and step transitions, apb registers
// Function
// - drive one of four boot codes pre-power-good
// - boot codes map to four fixed levels
// - serial carries seven bits, parallel six
// - internal code fields use seven-bit encoding
// - slam jumps straight to the new code
// - transitions on boot, reset, pstate, stop-grant
// - power-good slams to boot code
// - reset release slams to startup pstate code
// - pstate change slams or steps per slam select
// - alternate exit returns to captured pstate code
// - software sets codes via software code register
// - parallel mode drives only bridge code changes
// - pin 1 undriven pre-power-good, strap sampled
// - boot code on pins 3:2 or 5:2,0
// - seven to six bit translation in parallel
// - clamp codes to voltage limits first
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module vcs_sequencer (
  input wire clk,
  input wire rst,
  input wire power_good,
  input wire sys_reset_n,
  input wire alt_code_req,
  input wire [1:0] boot_strap,
  input wire [5:0] code_pin_in,
  output reg [5:0] code_pin_out,
  output reg [5:0] code_pin_oe_n,
  output reg [6:0] bridge_serial_code,
  output reg [6:0] core_serial_code,
  output reg serial_update,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);
`include "vcs_consts.vh"

  // -----------------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------------
  reg pg_meta_reg, pg_sync_reg, pg_prev_reg;
  reg rn_meta_reg, rn_sync_reg, rn_prev_reg;
  reg alt_meta_reg, alt_sync_reg, alt_prev_reg;
  reg strap_meta_reg, strap_sync_reg;
  localparam ST_OFF = 4'b0001;
  localparam ST_IDLE = 4'b0010;
  localparam ST_MOVE = 4'b0100;
  localparam ST_SETTLE = 4'b1000;
  reg [3:0] state_reg;
  reg busy_reg;
  wire idle = (state_reg == ST_IDLE);

  // two flops per asynchronous pin; only the second flop is read
  always @(posedge clk) begin
    if (rst) begin
      pg_meta_reg <= 1'b0;
      pg_sync_reg <= 1'b0;
      rn_meta_reg <= 1'b0;
      rn_sync_reg <= 1'b0;
      alt_meta_reg <= 1'b0;
      alt_sync_reg <= 1'b0;
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      pg_meta_reg <= power_good;
      pg_sync_reg <= pg_meta_reg;
      rn_meta_reg <= sys_reset_n;
      rn_sync_reg <= rn_meta_reg;
      alt_meta_reg <= alt_code_req;
      alt_sync_reg <= alt_meta_reg;
      strap_meta_reg <= code_pin_in[1];
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // edge history; reset and alternate edges wait for idle
  always @(posedge clk) begin
    if (rst) begin
      pg_prev_reg <= 1'b0;
      rn_prev_reg <= 1'b0;
      alt_prev_reg <= 1'b0;
    end else begin
      pg_prev_reg <= pg_sync_reg;
      if (idle) rn_prev_reg <= rn_sync_reg;
      if (idle) alt_prev_reg <= alt_sync_reg;
    end
  end

  wire pg_rise = pg_sync_reg & ~pg_prev_reg;
  wire rn_rise = rn_sync_reg & ~rn_prev_reg & pg_sync_reg;
  wire alt_rise = alt_sync_reg & ~alt_prev_reg;
  wire alt_fall = ~alt_sync_reg & alt_prev_reg;

  // -----------------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------------
  reg slam_select_reg;
  reg parallel_select_reg;
  reg [1:0] boot_sel_reg;
  reg [7:0] step_settle_time_reg;
  reg [7:0] jump_settle_time_reg;
  reg [2:0] pstate_reg;
  reg pstate_req_reg;
  reg [6:0] sw_bridge_reg, sw_core_reg;
  reg sw_req_reg;
  reg [6:0] max_voltage_limit_reg, min_voltage_limit_reg;
  reg [6:0] alt_code_reg;
  reg [13:0] ptab_reg [0:`VCS_NUM_PSTATE-1];
  reg [6:0] cur_bridge_reg, cur_core_reg;
  reg [7:0] settle_cnt_reg;

  wire apb_wr = psel & penable & pwrite;
  wire apb_setup = psel & ~penable;
  wire ptab_hit = (paddr >= `VCS_ADDR_PTAB0) && (paddr <= `VCS_ADDR_PTAB4) &&
                  (paddr[1:0] == 2'b00);
  wire [2:0] ptab_idx = paddr[4:2];
  wire known = (paddr == `VCS_ADDR_CTRL) || (paddr == `VCS_ADDR_PSTATE) ||
               (paddr == `VCS_ADDR_SWCODE) || (paddr == `VCS_ADDR_LIMIT) ||
               (paddr == `VCS_ADDR_STATUS) || ptab_hit;
  wire no_evt = idle & ~rn_rise & ~alt_rise & ~alt_fall;
  wire take_pstate = no_evt & pstate_req_reg;
  wire take_sw = no_evt & sw_req_reg & ~pstate_req_reg;

  // per-state table: bridge code in [13:7], core code in [6:0]
  genvar gi;
  generate
    for (gi = 0; gi < `VCS_NUM_PSTATE; gi = gi + 1) begin : g_ptab
      always @(posedge clk) begin
        if (rst) begin
          ptab_reg[gi] <= {`VCS_FACTORY_START, `VCS_FACTORY_START};
        end else if (apb_wr && ptab_hit && (ptab_idx == gi)) begin
          ptab_reg[gi] <= {pwdata[14:8], pwdata[6:0]};
        end
      end
    end
  endgenerate

  // software writes; a new request wins over its take
  always @(posedge clk) begin
    if (rst) begin
      slam_select_reg <= 1'b0;
      boot_sel_reg <= 2'b00;
      step_settle_time_reg <= `VCS_STEP_TIME_RST;
      jump_settle_time_reg <= `VCS_JUMP_TIME_RST;
      pstate_reg <= `VCS_STARTUP_PSTATE;
      pstate_req_reg <= 1'b0;
      sw_bridge_reg <= `VCS_FACTORY_START;
      sw_core_reg <= `VCS_FACTORY_START;
      sw_req_reg <= 1'b0;
      max_voltage_limit_reg <= `VCS_MAX_LIMIT_RST;
      min_voltage_limit_reg <= `VCS_MIN_LIMIT_RST;
    end else begin
      if (take_pstate) pstate_req_reg <= 1'b0;
      if (take_sw) sw_req_reg <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          `VCS_ADDR_CTRL: begin
            slam_select_reg <= pwdata[`VCS_CTRL_SLAM];
            boot_sel_reg <= pwdata[`VCS_CTRL_BOOT_HI:`VCS_CTRL_BOOT_LO];
            step_settle_time_reg <= pwdata[`VCS_CTRL_STEP_HI:`VCS_CTRL_STEP_LO];
            jump_settle_time_reg <= pwdata[`VCS_CTRL_JUMP_HI:`VCS_CTRL_JUMP_LO];
          end
          `VCS_ADDR_PSTATE: begin
            // out-of-range states are ignored
            if (pwdata[2:0] < `VCS_NUM_PSTATE) begin
              pstate_reg <= pwdata[2:0];
              pstate_req_reg <= 1'b1; // set wins over the clear above
            end
          end
          `VCS_ADDR_SWCODE: begin
            sw_bridge_reg <= pwdata[14:8];
            sw_core_reg <= pwdata[6:0];
            sw_req_reg <= 1'b1;
          end
          `VCS_ADDR_LIMIT: begin
            max_voltage_limit_reg <= pwdata[6:0];
            min_voltage_limit_reg <= pwdata[14:8];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // pready one cycle after setup; reads from flops
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~known;
      prdata <= 32'h0000_0000;
      if (apb_setup) begin
        if (paddr == `VCS_ADDR_CTRL) begin
          prdata <= {8'h00, jump_settle_time_reg, step_settle_time_reg, 4'h0,
                     parallel_select_reg, boot_sel_reg, slam_select_reg};
        end else if (paddr == `VCS_ADDR_PSTATE) begin
          prdata <= {29'h0000_0000, pstate_reg};
        end else if (paddr == `VCS_ADDR_SWCODE) begin
          prdata <= {17'h0_0000, sw_bridge_reg, 1'b0, sw_core_reg};
        end else if (paddr == `VCS_ADDR_LIMIT) begin
          prdata <= {17'h0_0000, min_voltage_limit_reg, 1'b0, max_voltage_limit_reg};
        end else if (paddr == `VCS_ADDR_STATUS) begin
          prdata <= {settle_cnt_reg, 1'b0, cur_bridge_reg, 1'b0, cur_core_reg,
                     6'h00, busy_reg, pg_sync_reg};
        end else if (ptab_hit) begin
          prdata <= {17'h0_0000, ptab_reg[ptab_idx][13:7], 1'b0, ptab_reg[ptab_idx][6:0]};
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // transition sequencer
  // -----------------------------------------------------------------------
  reg [6:0] tgt_bridge_reg, tgt_core_reg;
  reg slam_now_reg, upd_reg;
  reg [6:0] saved_bridge_reg, saved_core_reg;
  reg in_alt_reg;

  wire [6:0] ps_bridge = ptab_reg[pstate_reg][13:7];
  wire [6:0] ps_core = ptab_reg[pstate_reg][6:0];
  wire [6:0] start_bridge = ptab_reg[`VCS_STARTUP_PSTATE][13:7];
  wire [6:0] start_core = ptab_reg[`VCS_STARTUP_PSTATE][6:0];

  // new requests are only taken in idle, after settle expiry
  reg [6:0] req_bridge, req_core;
  reg req_valid, req_slam;
  always @* begin
    req_bridge = cur_bridge_reg;
    req_core = cur_core_reg;
    req_valid = 1'b0;
    req_slam = slam_select_reg;
    if (rn_rise) begin
      req_bridge = start_bridge;
      req_core = start_core;
      req_valid = 1'b1;
      req_slam = 1'b1;
    end else if (alt_rise) begin
      req_bridge = alt_code_reg;
      req_core = alt_code_reg;
      req_valid = 1'b1;
      req_slam = 1'b1;
    end else if (alt_fall) begin
      req_bridge = saved_bridge_reg;
      req_core = saved_core_reg;
      req_valid = 1'b1;
    end else if (pstate_req_reg) begin
      req_bridge = ps_bridge;
      req_core = ps_core;
      req_valid = 1'b1;
    end else if (sw_req_reg) begin
      req_bridge = sw_bridge_reg;
      req_core = sw_core_reg;
      req_valid = 1'b1;
    end
  end

  wire [6:0] flt_bridge, flt_core;
  vcs_code_filter u_filt_bridge (
    .code_in(req_bridge),
    .max_voltage_limit(max_voltage_limit_reg),
    .min_voltage_limit(min_voltage_limit_reg),
    .code_out(flt_bridge)
  );
  vcs_code_filter u_filt_core (
    .code_in(req_core),
    .max_voltage_limit(max_voltage_limit_reg),
    .min_voltage_limit(min_voltage_limit_reg),
    .code_out(flt_core)
  );

  // one increment toward target per step
  wire [6:0] step_bridge = (tgt_bridge_reg > cur_bridge_reg) ? cur_bridge_reg + `VCS_ONE7 :
                           (tgt_bridge_reg < cur_bridge_reg) ? cur_bridge_reg - `VCS_ONE7 :
                           cur_bridge_reg;
  wire [6:0] step_core = (tgt_core_reg > cur_core_reg) ? cur_core_reg + `VCS_ONE7 :
                         (tgt_core_reg < cur_core_reg) ? cur_core_reg - `VCS_ONE7 :
                         cur_core_reg;
  wire at_target = (cur_bridge_reg == tgt_bridge_reg) && (cur_core_reg == tgt_core_reg);

  // strap capture at power-good, then the boot slam
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_OFF;
      parallel_select_reg <= 1'b0;
      cur_bridge_reg <= `VCS_FACTORY_BOOT;
      cur_core_reg <= `VCS_FACTORY_BOOT;
      tgt_bridge_reg <= `VCS_FACTORY_BOOT;
      tgt_core_reg <= `VCS_FACTORY_BOOT;
      slam_now_reg <= 1'b1;
      settle_cnt_reg <= `VCS_ZERO8;
      busy_reg <= 1'b0;
      upd_reg <= 1'b0;
      saved_bridge_reg <= `VCS_FACTORY_START;
      saved_core_reg <= `VCS_FACTORY_START;
      in_alt_reg <= 1'b0;
    end else begin
      upd_reg <= 1'b0;
      case (state_reg)
        ST_OFF: begin
          if (pg_rise) begin
            parallel_select_reg <= strap_sync_reg;
            cur_bridge_reg <= `VCS_FACTORY_BOOT;
            cur_core_reg <= `VCS_FACTORY_BOOT;
            settle_cnt_reg <= jump_settle_time_reg;
            busy_reg <= 1'b1;
            state_reg <= ST_SETTLE;
          end
        end
        ST_IDLE: begin
          if (req_valid) begin
            if (alt_rise) begin
              saved_bridge_reg <= cur_bridge_reg;
              saved_core_reg <= cur_core_reg;
              in_alt_reg <= 1'b1;
            end
            if (alt_fall) in_alt_reg <= 1'b0;
            tgt_bridge_reg <= flt_bridge;
            tgt_core_reg <= flt_core;
            slam_now_reg <= req_slam;
            busy_reg <= 1'b1;
            state_reg <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (at_target) begin
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (slam_now_reg) begin
            cur_bridge_reg <= tgt_bridge_reg;
            cur_core_reg <= tgt_core_reg;
            settle_cnt_reg <= jump_settle_time_reg;
            upd_reg <= 1'b1;
            state_reg <= ST_SETTLE;
          end else begin
            cur_bridge_reg <= step_bridge;
            cur_core_reg <= step_core;
            settle_cnt_reg <= step_settle_time_reg;
            upd_reg <= 1'b1;
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_cnt_reg == `VCS_ZERO8) begin
            state_reg <= ST_MOVE;
          end else begin
            settle_cnt_reg <= settle_cnt_reg - `VCS_ONE8;
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
      // loss of power-good returns to boot presentation
      if (~pg_sync_reg && (state_reg != ST_OFF)) begin
        state_reg <= ST_OFF;
        busy_reg <= 1'b0;
      end
    end
  end

  // alternate code: follows the startup state's bridge code, held while in alternate
  always @(posedge clk) begin
    if (rst) begin
      alt_code_reg <= `VCS_FACTORY_START;
    end else if (~in_alt_reg) begin
      alt_code_reg <= start_bridge;
    end
  end

  // -----------------------------------------------------------------------
  // pin drive
  // -----------------------------------------------------------------------
  wire [5:0] six_bit_code;
  vcs_six_bit_xlat u_xlat (
    .seven_bit_code(cur_bridge_reg),
    .six_bit_code(six_bit_code)
  );

  reg [5:0] par_boot;
  always @* begin
    case (boot_sel_reg)
      2'b00: par_boot = `VCS_PAR_BOOT0;
      2'b01: par_boot = `VCS_PAR_BOOT1;
      2'b10: par_boot = `VCS_PAR_BOOT2;
      default: par_boot = `VCS_PAR_BOOT3;
    endcase
  end

  // pins registered; pin 1 released before power-good
  always @(posedge clk) begin
    if (rst) begin
      code_pin_out <= 6'h00;
      code_pin_oe_n <= 6'h02;
      bridge_serial_code <= `VCS_FACTORY_BOOT;
      core_serial_code <= `VCS_FACTORY_BOOT;
      serial_update <= 1'b0;
    end else begin
      bridge_serial_code <= cur_bridge_reg;
      core_serial_code <= cur_core_reg;
      serial_update <= upd_reg; // pulse lands with the new codes
      if (~pg_sync_reg) begin
        code_pin_oe_n <= 6'h02;
        if (strap_sync_reg) begin
          code_pin_out <= par_boot;
        end else begin
          code_pin_out <= {2'b00, boot_strap, 2'b00};
        end
      end else if (parallel_select_reg) begin
        code_pin_oe_n <= 6'h00;
        code_pin_out <= six_bit_code;
      end else begin
        // serial framing lives elsewhere; all six pins driven low here
        code_pin_oe_n <= 6'h00;
        code_pin_out <= 6'h00;
      end
    end
  end
endmodule

// ===== logic/vcs_consts.vh
// constants shared by the voltage code sequencer files
`ifndef VCS_CONSTS_VH
`define VCS_CONSTS_VH
// -----------------------------------------------------------------------
// register map (byte addresses)
// -----------------------------------------------------------------------
`define VCS_ADDR_CTRL 12'h000
`define VCS_ADDR_PSTATE 12'h004
`define VCS_ADDR_SWCODE 12'h008
`define VCS_ADDR_LIMIT 12'h00C
`define VCS_ADDR_STATUS 12'h010
`define VCS_ADDR_PTAB0 12'h020
`define VCS_ADDR_PTAB4 12'h030
// -----------------------------------------------------------------------
// control register fields and reset values
// -----------------------------------------------------------------------
`define VCS_CTRL_SLAM 0
`define VCS_CTRL_BOOT_LO 1
`define VCS_CTRL_BOOT_HI 2
`define VCS_CTRL_STEP_LO 8
`define VCS_CTRL_STEP_HI 15
`define VCS_CTRL_JUMP_LO 16
`define VCS_CTRL_JUMP_HI 23
`define VCS_STEP_TIME_RST 8'h0_4
`define VCS_JUMP_TIME_RST 8'h1_0
`define VCS_MAX_LIMIT_RST 7'h0_0
`define VCS_MIN_LIMIT_RST 7'h0_0
`define VCS_STARTUP_PSTATE 3'h4
`define VCS_NUM_PSTATE 5
// -----------------------------------------------------------------------
// boot codes and six-bit translation bounds
// -----------------------------------------------------------------------
`define VCS_PAR_BOOT0 6'h1_2
`define VCS_PAR_BOOT1 6'h1_6
`define VCS_PAR_BOOT2 6'h1_A
`define VCS_PAR_BOOT3 6'h1_E
`define VCS_FACTORY_BOOT 7'h2_4
`define VCS_FACTORY_START 7'h3_0
`define VCS_XLAT_TOP 7'h5_E
`define VCS_XLAT_MID 7'h3_F
`define VCS_XLAT_SUB 7'h1_F
`define VCS_SIX_MAX 6'h3_F
`define VCS_ZERO7 7'h0_0
`define VCS_ONE7 7'h0_1
`define VCS_ZERO8 8'h0_0
`define VCS_ONE8 8'h0_1
`endif

// ===== logic/vcs_code_filter.v
// clamps a seven-bit supply code to the configured limits
`timescale 1ns/100ps
module vcs_code_filter (
  input wire [6:0] code_in,
  input wire [6:0] max_voltage_limit,
  input wire [6:0] min_voltage_limit,
  output reg [6:0] code_out
);
`include "vcs_consts.vh"
  // lower code is higher voltage, so the max limit is a lower bound on code
  always @* begin
    if (code_in < max_voltage_limit) begin
      code_out = max_voltage_limit;
    end else if ((code_in > min_voltage_limit) && (min_voltage_limit != `VCS_ZERO7)) begin
      code_out = min_voltage_limit;
    end else begin
      code_out = code_in;
    end
  end
endmodule

// ===== logic/vcs_six_bit_xlat.v
// translates the internal seven-bit code to the six-bit parallel code
`timescale 1ns/100ps
module vcs_six_bit_xlat (
  input wire [6:0] seven_bit_code,
  output reg [5:0] six_bit_code
);
`include "vcs_consts.vh"
  wire [6:0] mid_code = seven_bit_code - `VCS_XLAT_SUB;
  // three bands: floor, 12.5 mV band shifted down, 25 mV band halved
  always @* begin
    if (seven_bit_code >= `VCS_XLAT_TOP) begin
      six_bit_code = `VCS_SIX_MAX;
    end else if (seven_bit_code >= `VCS_XLAT_MID) begin
      six_bit_code = mid_code[5:0];
    end else begin
      six_bit_code = seven_bit_code[6:1];
    end
  end
endmodule

// ===== verif/vcs_sequencer_assertions.sv
// port assertions for the voltage code sequencer
`timescale 1ns/100ps
module vcs_sequencer_assertions (
  input clk,
  input rst,
  input power_good,
  input [1:0] boot_strap,
  input [5:0] code_pin_in,
  input [5:0] code_pin_out,
  input [5:0] code_pin_oe_n,
  input [6:0] bridge_serial_code,
  input [6:0] core_serial_code,
  input serial_update,
  input psel,
  input penable,
  input pwrite,
  input [11:0] paddr,
  input [31:0] pwdata,
  input pready,
  input pslverr
);
  // ---------------------------------------------------------------
  // shadow state and properties
  // ---------------------------------------------------------------
  reg par_reg;
  reg prev_big;
  reg [7:0] step_reg;
  reg [7:0] jump_reg;
  reg [7:0] gap_reg;
  reg [6:0] max_reg;
  reg [6:0] min_reg;
  reg [6:0] last_reg;
  wire [6:0] delta = bridge_serial_code - last_reg;
  wire stepd = (delta == 7'h01) || (delta == 7'h7F);
  wire wr = psel && penable && pready && pwrite;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= 12'h010 || (paddr >= 12'h020 && paddr <= 12'h030));
  function [5:0] xl(input [6:0] c);
    xl = (c >= 7'h5E) ? 6'h3F : (c >= 7'h3F) ? c[5:0] - 6'h1F : c[6:1];
  endfunction
  // strap seen while pin 1 released
  always @(posedge clk) begin
    if (!power_good) begin
      par_reg <= code_pin_in[1];
    end
  end
  // mirrors; gap saturates so long idles never wrap
  always @(posedge clk) begin
    if (rst) begin
      step_reg <= 8'h04;
      jump_reg <= 8'h10;
      max_reg <= 7'h00;
      min_reg <= 7'h00;
      gap_reg <= 8'hFF;
      prev_big <= 1'b0;
      last_reg <= 7'h24;
    end else begin
      if (wr && paddr == 12'h000) begin
        step_reg <= pwdata[15:8];
        jump_reg <= pwdata[23:16];
      end
      if (wr && paddr == 12'h00C) begin
        max_reg <= pwdata[6:0];
        min_reg <= pwdata[14:8];
      end
      if (serial_update) begin
        gap_reg <= 8'h00;
        prev_big <= !stepd;
        last_reg <= bridge_serial_code;
      end else if (gap_reg != 8'hFF) begin
        gap_reg <= gap_reg + 8'h01;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  sequence s_off; (!power_good) [*6]; endsequence
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("apb not answered");
  a_unmapped_err: assert property (psel && penable && pready && !mapped |-> pslverr)
    else $error("no error on unmapped");
  a_pin_release: assert property (s_off |-> code_pin_oe_n[1])
    else $error("pin 1 driven early");
  a_serial_boot: assert property (s_off ##0 !par_reg |-> code_pin_out[3:2] == boot_strap)
    else $error("serial boot code wrong");
  a_par_boot: assert property (s_off ##0 par_reg |->
    (code_pin_out & 6'h3D) inside {6'h10, 6'h14, 6'h18, 6'h1C})
    else $error("bad parallel boot code");
  a_update_marks: assert property (serial_update ==
    ($changed(bridge_serial_code) || $changed(core_serial_code)))
    else $error("update pulse mismatch");
  a_step_settle: assert property (serial_update && !prev_big |-> gap_reg >= step_reg)
    else $error("step settle short");
  a_slam_settle: assert property (serial_update && prev_big |-> gap_reg >= jump_reg)
    else $error("slam settle short");
  a_slam_limits: assert property (serial_update && !stepd |->
    bridge_serial_code >= max_reg && (min_reg == 7'h00 || bridge_serial_code <= min_reg))
    else $error("code outside limits");
  a_par_xlat: assert property (par_reg && power_good && serial_update |->
    ##[0:3] code_pin_out == xl(bridge_serial_code))
    else $error("parallel pins wrong");
endmodule
bind vcs_sequencer vcs_sequencer_assertions chk_inst (.*);

// ===== verif/vcs_regulator_model.sv
// regulator model: strap resistor on pin 1 and decoded supply level
`timescale 1ns/100ps
module vcs_regulator_model (
  input wire clk,
  input wire par_strap,
  input wire power_good,
  input wire [5:0] code_pin_out,
  input wire [5:0] code_pin_oe_n,
  input wire [6:0] bridge_serial_code,
  input wire serial_update,
  output wire [5:0] code_pin_in,
  output reg [15:0] level
);
  // ---------------------------------------------------------------
  // pins and level, level in units of 0.1 mV
  // ---------------------------------------------------------------
  // released pin 1 shows the strap, others the inverse
  assign code_pin_in = (code_pin_out & ~code_pin_oe_n)
    | (~code_pin_out & code_pin_oe_n & 6'h3D)
    | ({6{par_strap}} & code_pin_oe_n & 6'h02);
  function [15:0] pv(input [5:0] c);
    pv = c[5] ? 16'h1DC9 - 16'h007D * c[4:0] : 16'h3C8C - 16'h00FA * c;
  endfunction
  function [15:0] sv(input [6:0] c);
    sv = (c >= 7'h7C) ? 16'h0000 : 16'h3C8C - 16'h007D * c;
  endfunction
  // boot level first, then follow whichever interface is active
  always @(posedge clk) begin
    if (!power_good) begin
      level <= par_strap ? pv(code_pin_in) : 16'h2AF8 - 16'h03E8 * code_pin_out[3:2];
    end else if (par_strap) begin
      level <= pv(code_pin_out);
    end else if (serial_update) begin
      level <= sv(bridge_serial_code);
    end
  end
endmodule

// ===== verif/test_voltage_code_sequencer.sv
// self-checking bench for the voltage code sequencer
`timescale 1ns/100ps
module test_voltage_code_sequencer;
  // ---------------------------------------------------------------
  // stimulus, models and bookkeeping
  // ---------------------------------------------------------------
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg power_good = 1'b0;
  reg sys_reset_n = 1'b0;
  reg alt_code_req = 1'b0;
  reg par_strap = 1'b0;
  reg [1:0] boot_strap = 2'h0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [31:0] rd;
  reg rd_err;
  reg [6:0] code;
  wire [5:0] code_pin_in, code_pin_out, code_pin_oe_n;
  wire [6:0] bridge_serial_code, core_serial_code;
  wire serial_update, pready, pslverr;
  wire [31:0] prdata;
  wire [15:0] level;
  logic [6:0] exp_q[$];
  logic [6:0] par_code [0:2] = '{7'h5F, 7'h45, 7'h2C};
  logic [5:0] par_pin [0:2] = '{6'h3F, 6'h26, 6'h16};
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i;
  vcs_sequencer vcs_sequencer_inst (.*);
  vcs_regulator_model reg_model (.clk(clk), .par_strap(par_strap), .power_good(power_good),
    .code_pin_out(code_pin_out), .code_pin_oe_n(code_pin_oe_n), .level(level),
    .bridge_serial_code(bridge_serial_code), .serial_update(serial_update),
    .code_pin_in(code_pin_in));
  initial begin
    forever #10 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watcher: each update against the oldest note
  always @(negedge clk) begin
    if (serial_update === 1'b1) begin
      if (exp_q.size() == 0)
        chk(32'h0000_0001, 32'h0000_0000);
      else
        chk(bridge_serial_code, exp_q.pop_front());
    end
  end
  // a hang is cut short here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  // apb transfer, waits on pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task drain;
    for (i = 0; i < 600 && exp_q.size() != 0; i = i + 1) @(posedge clk);
    @(posedge clk);
    chk(exp_q.size(), 0);
  endtask
  task move_to(input logic [2:0] p, input logic [6:0] b, input logic [6:0] c);
    apb(1'b1, 12'h020 + {7'h00, p, 2'b00}, {17'h0_0000, b, 1'b0, c});
    apb(1'b1, 12'h004, {29'h0000_0000, p});
  endtask
  // power-up with a strap, then reset release
  task power_up(input logic strap);
    rst <= 1'b1;
    power_good <= 1'b0;
    sys_reset_n <= 1'b0;
    par_strap <= strap;
    boot_strap <= 2'($urandom);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk(code_pin_oe_n[1], 1'b1);
    if (strap)
      chk((code_pin_out & 6'h3D) inside {6'h10, 6'h14, 6'h18, 6'h1C}, 1'b1);
    else
      chk(code_pin_out[3:2], boot_strap);
    power_good <= 1'b1;
    repeat (6) @(posedge clk);
    chk(bridge_serial_code, 7'h24);
    if (!strap)
      chk(level, 16'h2AF8 - 16'h03E8 * boot_strap);
    exp_q.push_back(7'h30);
    sys_reset_n <= 1'b1;
    drain;
    $display("test power-up done");
  endtask
  initial begin
    void'($urandom(32'h7058_1fc6));
    power_up(1'b0);
    for (i = 1; i <= 4; i = i + 1) exp_q.push_back(7'h30 - i);
    move_to(3'd0, 7'h2C, 7'h2C);
    drain;
    chk(level, 16'h2710);
    $display("test stepped move done");
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd[23:8], 16'h1004);
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk(rd_err, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0005);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test register access done");
    apb(1'b1, 12'h000, 32'h0010_0401);
    for (int p = 1; p <= 3; p++) begin
      code = 7'h38 + 7'(8 * p) + 7'($urandom % 8);
      exp_q.push_back(code);
      move_to(3'(p), code, code);
      drain;
    end
    repeat (40) @(posedge clk);
    exp_q.push_back(7'h30);
    alt_code_req <= 1'b1;
    drain;
    repeat (40) @(posedge clk);
    exp_q.push_back(code);
    alt_code_req <= 1'b0;
    drain;
    exp_q.push_back(7'h7D);
    apb(1'b1, 12'h008, {17'h0_0000, 7'h7D, 1'b0, 7'h7D});
    drain;
    chk(level, 16'h0000);
    apb(1'b1, 12'h00C, 32'h0000_0035);
    exp_q.push_back(7'h35);
    move_to(3'd4, 7'h20, 7'h20);
    drain;
    apb(1'b1, 12'h00C, 32'h0000_5000);
    exp_q.push_back(7'h50);
    move_to(3'd2, 7'h60, 7'h60);
    drain;
    $display("test slam, alternate, software and limits done");
    power_up(1'b1);
    apb(1'b1, 12'h000, 32'h0010_0401);
    for (int p = 0; p < 3; p++) begin
      exp_q.push_back(par_code[p]);
      move_to(3'(p), par_code[p], 7'h10);
      drain;
      repeat (3) @(posedge clk);
      chk(code_pin_out, par_pin[p]);
    end
    $display("test parallel translation done");
    tally_and_finish;
  end
endmodule
